// File: core/shp_pkg.sv
// Purpose: constants for the slave-mode host byte port
// Assumes: one core clock domain, host pins asynchronous to it
// Notes: host mode and slave mode share the fourteen pins
// Function
// - device pulls write-ready low when it can accept a byte
// - strobe rise in write: latch data, write-ready high, write-done interrupt
// - slave mode: port d bits 0..3 are write-ready, read-ready, strobe, select
// - slave mode: only port d bits 4,5 stay general purpose with interrupts
// - slave mode: data pins are a bus steered by strobe and select
// - interrupts come from transitions on port d bits 2..5
// - port d interrupts work whether pins are inputs or outputs
// - no software setting selects slave mode; only the pins govern it
// - host mode: six pins are port d bits 0..5, eight are a gpio port
// - host mode keeps all port d functions: four interrupts, branch, comparator
// - device pulls read-ready low once the core has filled the output latch
// - read: host select high then strobe low; device drives latched byte
// - strobe rise in read: read-ready high, bus released, read-done interrupt
// - core writing the output latch pulls read-ready low again
package shp_pkg;
	localparam int DATA_W = 8;
	localparam int PD_W = 6;
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [5:0] PD_RST = 6'h00;
	// strobe and select idle high
	localparam logic [5:0] PD_IDLE = 6'h0c;
	// port d bit positions
	localparam int PD_WR_RDY = 0;
	localparam int PD_RD_RDY = 1;
	localparam int PD_STROBE = 2;
	localparam int PD_SELECT = 3;
	localparam int PD_GP4 = 4;
	localparam int PD_GP5 = 5;
endpackage

// File: core/shp_sync.sv
// Purpose: two-flop synchroniser for asynchronous host levels
// Assumes: input asynchronous to i_clk
// Notes: first stage read only by second stage
`timescale 1ns/10ps
module shp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			meta_q <= RST_VAL;
			o_sync <= RST_VAL;
		end
		else
		begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// File: core/shp_port.sv
// Purpose: fourteen-pin port: slave byte port to a host or plain gpio
// Assumes: host pins asynchronous, sampled through shp_sync
// Notes: mode comes from a pin, not from software
`timescale 1ns/10ps
module shp_port #(
	parameter int DATA_W = shp_pkg::DATA_W,
	parameter int PD_W = shp_pkg::PD_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// mode strap: high selects slave mode
	input wire logic i_slave_mode,
	// data port pins
	input wire logic [DATA_W-1:0] i_data_port_pins,
	output logic [DATA_W-1:0] o_data_port_pins,
	output logic [DATA_W-1:0] o_data_port_pins_oe,
	// port d pins
	input wire logic [PD_W-1:0] i_port_d_pins,
	output logic [PD_W-1:0] o_port_d_pins,
	output logic [PD_W-1:0] o_port_d_pins_oe,
	// core side: byte latches
	input wire logic i_core_in_latch_rd,
	output logic [DATA_W-1:0] o_core_in_latch,
	input wire logic i_core_out_latch_wr,
	input wire logic [DATA_W-1:0] i_core_out_latch,
	// core side: host mode gpio
	input wire logic [DATA_W-1:0] i_core_c_data,
	input wire logic [DATA_W-1:0] i_core_c_dir,
	input wire logic [PD_W-1:0] i_core_d_data,
	input wire logic [PD_W-1:0] i_core_d_dir,
	output logic [DATA_W-1:0] o_core_c_pins,
	output logic [PD_W-1:0] o_core_d_pins,
	// core side: interrupts, pulses
	output logic o_write_done_interrupt,
	output logic o_read_done_interrupt,
	output logic o_int_d4_rise,
	output logic o_int_d5_fall
);
	logic mode_q;
	logic [PD_W-1:0] pd_s;
	logic [DATA_W-1:0] pc_s;
	logic [PD_W-1:0] pd_lvl;
	logic [PD_W-1:0] pd_prev_q;
	logic strobe_rise;
	logic host_write_ready_n_q;
	logic host_read_ready_n_q;
	logic [DATA_W-1:0] out_latch_q;
	logic rd_drive_d;

	// strap sampled every clock; no register reaches it
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			mode_q <= 1'b0;
		else
			mode_q <= i_slave_mode;
	end

	// host strobe, select and gpio levels synchronised
	shp_sync #(.WIDTH(PD_W), .RST_VAL(shp_pkg::PD_IDLE)) u_sync_d (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_port_d_pins),
		.o_sync(pd_s)
	);
	shp_sync #(.WIDTH(DATA_W), .RST_VAL(shp_pkg::DATA_RST)) u_sync_c (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_data_port_pins),
		.o_sync(pc_s)
	);

	// seen level: driven value for outputs, pin for inputs
	always_comb
	begin
		pd_lvl = (o_port_d_pins_oe & o_port_d_pins) | (~o_port_d_pins_oe & pd_s);
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			pd_prev_q <= shp_pkg::PD_IDLE;
		else
			pd_prev_q <= pd_lvl;
	end

	assign strobe_rise = mode_q && pd_lvl[shp_pkg::PD_STROBE] && !pd_prev_q[shp_pkg::PD_STROBE];

	// transition interrupts on d2..d5 in host mode; on d2 rise, d4 and d5 only in slave mode
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_write_done_interrupt <= 1'b0;
			o_read_done_interrupt <= 1'b0;
			o_int_d4_rise <= 1'b0;
			o_int_d5_fall <= 1'b0;
		end
		else
		begin
			if (mode_q)
			begin
				o_write_done_interrupt <= strobe_rise && !pd_lvl[shp_pkg::PD_SELECT];
				o_read_done_interrupt <= strobe_rise && pd_lvl[shp_pkg::PD_SELECT];
			end
			else
			begin
				o_write_done_interrupt <= pd_lvl[shp_pkg::PD_STROBE] && !pd_prev_q[shp_pkg::PD_STROBE];
				o_read_done_interrupt <= !pd_lvl[shp_pkg::PD_SELECT] && pd_prev_q[shp_pkg::PD_SELECT];
			end
			o_int_d4_rise <= pd_lvl[shp_pkg::PD_GP4] && !pd_prev_q[shp_pkg::PD_GP4];
			o_int_d5_fall <= !pd_lvl[shp_pkg::PD_GP5] && pd_prev_q[shp_pkg::PD_GP5];
		end
	end

	// input latch and write-ready handshake
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_core_in_latch <= shp_pkg::DATA_RST;
			host_write_ready_n_q <= 1'b0;
		end
		else if (strobe_rise && !pd_lvl[shp_pkg::PD_SELECT])
		begin
			o_core_in_latch <= pc_s;
			host_write_ready_n_q <= 1'b1;
		end
		else if (i_core_in_latch_rd)
			host_write_ready_n_q <= 1'b0;
	end

	// output latch and read-ready handshake
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			out_latch_q <= shp_pkg::DATA_RST;
			host_read_ready_n_q <= 1'b1;
		end
		else if (strobe_rise && pd_lvl[shp_pkg::PD_SELECT])
			host_read_ready_n_q <= 1'b1;
		else if (i_core_out_latch_wr)
		begin
			out_latch_q <= i_core_out_latch;
			host_read_ready_n_q <= 1'b0;
		end
	end

	// bus driven while select high and strobe low
	assign rd_drive_d = mode_q && pd_s[shp_pkg::PD_SELECT] && !pd_s[shp_pkg::PD_STROBE] && !strobe_rise;

	// pin drivers
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_data_port_pins <= shp_pkg::DATA_RST;
			o_data_port_pins_oe <= shp_pkg::DATA_RST;
			o_port_d_pins <= shp_pkg::PD_RST;
			o_port_d_pins_oe <= shp_pkg::PD_RST;
		end
		else if (mode_q)
		begin
			o_data_port_pins <= out_latch_q;
			o_data_port_pins_oe <= {DATA_W{rd_drive_d}};
			o_port_d_pins <= {i_core_d_data[5:4], 1'b0, 1'b0, host_read_ready_n_q, host_write_ready_n_q};
			o_port_d_pins_oe <= {i_core_d_dir[5:4], 4'h3};
		end
		else
		begin
			o_data_port_pins <= i_core_c_data;
			o_data_port_pins_oe <= i_core_c_dir;
			o_port_d_pins <= i_core_d_data;
			o_port_d_pins_oe <= i_core_d_dir;
		end
	end

	// pin levels back to the core for branch and comparator use
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_core_c_pins <= shp_pkg::DATA_RST;
			o_core_d_pins <= shp_pkg::PD_RST;
		end
		else
		begin
			o_core_c_pins <= pc_s;
			o_core_d_pins <= pd_lvl;
		end
	end

	a_write_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(strobe_rise && !pd_lvl[shp_pkg::PD_SELECT]) |=> (o_write_done_interrupt && o_port_d_pins[0] == 1'b0 ##1
		o_port_d_pins[0] && o_core_in_latch == $past(pc_s, 2)))
		else $error("write strobe did not latch data");
	a_read_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(strobe_rise && pd_lvl[shp_pkg::PD_SELECT]) |=> ##1 (o_data_port_pins_oe == 8'h00 && o_port_d_pins[1]))
		else $error("read strobe did not release bus");
	a_rd_ready_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(mode_q && i_core_out_latch_wr && !strobe_rise) |=> ##1 !o_port_d_pins[1])
		else $error("read-ready not lowered");
	a_wr_ready_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(mode_q && $stable(mode_q) && i_core_in_latch_rd && !strobe_rise) |=> ##1 !o_port_d_pins[0])
		else $error("write-ready not lowered");
	a_one_event: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		strobe_rise |=> !strobe_rise)
		else $error("double strobe event");
	a_strobe_sync: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(strobe_rise && $past(mode_q) && $past(mode_q, 2)) |->
		($past(i_port_d_pins[shp_pkg::PD_STROBE], 2) && !$past(i_port_d_pins[shp_pkg::PD_STROBE], 3)))
		else $error("strobe edge not taken through synchroniser");
	a_drive_bus: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_drive_d) |=> (o_data_port_pins_oe == 8'hff && o_data_port_pins == $past(out_latch_q)))
		else $error("read byte not driven");
	a_slave_dir: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		mode_q |=> o_port_d_pins_oe[3:0] == 4'h3)
		else $error("handshake pin direction wrong");
	a_d4_int: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(pd_lvl[4] && !pd_prev_q[4]) |=> o_int_d4_rise)
		else $error("d4 interrupt missed");
	a_host_gpio: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!mode_q |=> o_data_port_pins_oe == $past(i_core_c_dir))
		else $error("host mode gpio direction wrong");

	c_write: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_write_done_interrupt && mode_q);
	c_read: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_read_done_interrupt && mode_q);
	c_d5: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_int_d5_fall);
endmodule

// File: sim/shp_host_model.sv
// Purpose: host microprocessor model for the byte port
// Assumes: drives its lines at the falling clock edge
// Notes: undriven data lines toggle every clock
`timescale 1ns/10ps
module shp_host_model (
	// clock
	input wire logic i_clk,
	// device drive
	input wire logic [7:0] i_dev_data,
	input wire logic [7:0] i_dev_data_oe,
	input wire logic [5:0] i_dev_d,
	input wire logic [5:0] i_dev_d_oe,
	// resolved wire levels
	output logic [7:0] o_data,
	output logic [5:0] o_d
);
	logic [5:0] h_d = 6'h0c;
	logic [7:0] h_data = 8'h00;
	logic h_en = 1'b0;
	logic [7:0] idle_q = 8'h55;
	always @(posedge i_clk)
		idle_q <= ~idle_q;
	assign o_data = (i_dev_data_oe & i_dev_data) | (~i_dev_data_oe & (h_en ? h_data : idle_q));
	assign o_d = (i_dev_d_oe & i_dev_d) | (~i_dev_d_oe & h_d);
	task automatic write_byte(input logic [7:0] b);
		@(negedge i_clk);
		h_d[3] = 1'b0;
		h_data = b;
		h_en = 1'b1;
		@(negedge i_clk);
		h_d[2] = 1'b0;
		repeat (4) @(negedge i_clk);
		h_d[2] = 1'b1;
		repeat (3) @(negedge i_clk);
		h_en = 1'b0;
	endtask
	task automatic read_byte(output logic [7:0] b);
		@(negedge i_clk);
		h_d[3] = 1'b1;
		@(negedge i_clk);
		h_d[2] = 1'b0;
		repeat (4) @(negedge i_clk);
		b = o_data;
		h_d[2] = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask
endmodule

// File: sim/tb.sv
// Purpose: bench for the slave-mode host byte port
// Assumes: inputs change at the falling clock edge
// Notes: interrupt pulses are counted each clock
`timescale 1ns/10ps
module tb;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic slv = 1'b1;
	logic in_rd = 1'b0;
	logic out_wr = 1'b0;
	logic [7:0] out_b = 8'h00;
	logic [7:0] c_data = 8'h00;
	logic [7:0] c_dir = 8'h00;
	logic [5:0] d_data = 6'h00;
	logic [5:0] d_dir = 6'h00;
	logic [7:0] w_c, dev_c, dev_c_oe, in_l, c_pins, rb;
	logic [5:0] w_d, dev_d, dev_d_oe, d_pins;
	logic wd, rdn, i4, i5;
	int n_wd = 0, n_rd = 0, n_i4 = 0, n_i5 = 0, n_errors = 0, num_checks = 0;
	shp_port u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slave_mode(slv), .i_data_port_pins(w_c),
		.o_data_port_pins(dev_c), .o_data_port_pins_oe(dev_c_oe), .i_port_d_pins(w_d), .o_port_d_pins(dev_d),
		.o_port_d_pins_oe(dev_d_oe), .i_core_in_latch_rd(in_rd), .o_core_in_latch(in_l),
		.i_core_out_latch_wr(out_wr), .i_core_out_latch(out_b), .i_core_c_data(c_data), .i_core_c_dir(c_dir),
		.i_core_d_data(d_data), .i_core_d_dir(d_dir), .o_core_c_pins(c_pins), .o_core_d_pins(d_pins),
		.o_write_done_interrupt(wd), .o_read_done_interrupt(rdn), .o_int_d4_rise(i4), .o_int_d5_fall(i5));
	shp_host_model u_host (.i_clk(i_clk), .i_dev_data(dev_c), .i_dev_data_oe(dev_c_oe), .i_dev_d(dev_d),
		.i_dev_d_oe(dev_d_oe), .o_data(w_c), .o_d(w_d));
	initial
	begin
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		n_wd <= n_wd + int'(wd === 1'b1);
		n_rd <= n_rd + int'(rdn === 1'b1);
		n_i4 <= n_i4 + int'(i4 === 1'b1);
		n_i5 <= n_i5 + int'(i5 === 1'b1);
	end
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one-cycle core access to a latch
	task automatic core_op(input logic wr);
		@(negedge i_clk);
		in_rd = !wr;
		out_wr = wr;
		@(negedge i_clk);
		in_rd = 1'b0;
		out_wr = 1'b0;
		tick(2);
	endtask
	task automatic t_reset();
		check("ready_pins", 8'(dev_d[1:0]), 8'h02);
		check("d_oe", 8'(dev_d_oe), 8'h03);
		check("c_oe", dev_c_oe, 8'h00);
	endtask
	task automatic t_write();
		logic [7:0] v [2] = '{8'ha5, 8'h5a};
		foreach (v[k])
		begin
			u_host.write_byte(v[k]);
			tick(2);
			check("in_latch", in_l, v[k]);
			check("wr_ready", 8'(dev_d[0]), 8'h01);
			check("wr_done", 8'(n_wd), 8'(k + 1));
			core_op(1'b0);
			check("wr_ready", 8'(dev_d[0]), 8'h00);
		end
	endtask
	task automatic t_read();
		out_b = 8'h3c;
		core_op(1'b1);
		check("rd_ready", 8'(dev_d[1]), 8'h00);
		u_host.read_byte(rb);
		check("rd_byte", rb, 8'h3c);
		tick(2);
		check("c_oe", dev_c_oe, 8'h00);
		check("rd_ready", 8'(dev_d[1]), 8'h01);
		check("rd_done", 8'(n_rd), 8'h01);
		check("wr_done", 8'(n_wd), 8'h02);
	endtask
	task automatic t_gpio();
		d_dir = 6'h10;
		u_host.h_d[5] = 1'b1;
		tick(4);
		d_data = 6'h10;
		u_host.h_d[5] = 1'b0;
		tick(5);
		check("d_oe", 8'(dev_d_oe), 8'h13);
		check("d4_pin", 8'(dev_d[4]), 8'h01);
		check("d4_rise", 8'(n_i4), 8'h01);
		check("d5_fall", 8'(n_i5), 8'h01);
	endtask
	task automatic t_host();
		slv = 1'b0;
		d_dir = 6'h00;
		c_dir = 8'hff;
		c_data = 8'h5a;
		u_host.h_d = 6'h00;
		tick(3);
		check("c_out", dev_c, 8'h5a);
		check("c_oe", dev_c_oe, 8'hff);
		check("d_oe", 8'(dev_d_oe), 8'h00);
		u_host.h_d = 6'h14;
		c_dir = 8'h00;
		u_host.h_data = 8'hc3;
		u_host.h_en = 1'b1;
		tick(5);
		check("c_pins", c_pins, 8'hc3);
		check("d_pins", 8'(d_pins), 8'h14);
		check("d2_rise", 8'(n_wd), 8'h03);
		check("d3_fall", 8'(n_rd), 8'h02);
		check("d4_rise", 8'(n_i4), 8'h02);
	endtask
	initial
	begin
		tick(6);
		i_reset_n = 1'b1;
		tick(3);
		t_reset();
		t_write();
		t_read();
		t_gpio();
		t_host();
		conclude();
	end
	initial
	begin
		#100000;
		n_errors++;
		conclude();
	end
endmodule
